// ### bench/flash_front_chk.sv
`timescale 1ns/1ps
module flash_front_chk #(
  parameter [23:0] WR_CYCLES = 24'd500
) (
  input wire ref_clk,
  input wire arst_n,
  input wire sclk,
  input wire csN,
  input wire [3:0] ioIn,
  input wire [3:0] ioOut_r,
  input wire [3:0] ioOe_r,
  input wire [15:0] statusWord_r,
  input wire fourWireMode_r
);
  logic [23:0] busyCnt;

  // counts how long the busy bit has stood high
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busyCnt <= 24'h000000;
    end else if (statusWord_r[0]) begin
      busyCnt <= busyCnt + 24'h000001;
    end else begin
      busyCnt <= 24'h000000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence csIdle;
    csN [*6];
  endsequence
  sequence busyEnd;
    $fell(statusWord_r[0]);
  endsequence

  chk_bit15_zero: assert property (statusWord_r[15] == 1'b0)
    else $error("status bit 15 set");
  chk_oe_released: assert property (csIdle |-> ioOe_r == 4'h0)
    else $error("lines driven outside frame");
  chk_oe_quad: assert property (
    fourWireMode_r && ioOe_r != 4'h0 |-> ioOe_r == 4'hf)
    else $error("four-wire output not on all lines");
  chk_mode_qe: assert property (
    $rose(fourWireMode_r) |-> statusWord_r[9])
    else $error("four-wire mode without quad enable");
  chk_mode_idle: assert property ($changed(fourWireMode_r) |-> csN)
    else $error("mode changed inside frame");
  chk_mode_wel: assert property (
    $changed(fourWireMode_r) |-> $stable(statusWord_r[1]) ##1
    $stable(statusWord_r[1]))
    else $error("latch changed with mode");
  chk_busy_max: assert property (
    statusWord_r[0] |-> busyCnt < WR_CYCLES + 24'd2)
    else $error("busy too long");
  chk_busy_min: assert property (
    busyEnd |-> busyCnt + 24'd2 >= WR_CYCLES)
    else $error("busy too short");
  chk_wel_end: assert property (busyEnd |-> ##[0:2] !statusWord_r[1])
    else $error("latch not cleared after cycle");
  chk_sr_idle: assert property (
    $changed(statusWord_r[15:2]) |-> csN || $past(statusWord_r[0]))
    else $error("status changed inside frame");
endmodule // flash_front_chk

// ### bench/serial_flash_config_status_cmds_bench.sv
`timescale 1ns/1ps
module serial_flash_config_status_cmds_bench;
  localparam int WRC = 400;
  logic ref_clk;
  logic arst_n;
  wire sclk;
  wire csN;
  wire [3:0] hostIo;
  wire [3:0] ioOut_r;
  wire [3:0] ioOe_r;
  wire [15:0] statusWord_r;
  wire fourWireMode_r;
  wire [3:0] ioWire = (ioOe_r & ioOut_r) | (~ioOe_r & hostIo);
  int badCount;
  int nCompared;
  int seed;
  int w;
  logic [7:0] expQ[$];
  logic [7:0] e;
  logic [7:0] r;
  logic [7:0] r2;

  flash_cmd_front #(.WR_CYCLES(24'(WRC))) dut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sclk(sclk),
    .csN(csN),
    .ioIn(ioWire),
    .ioOut_r(ioOut_r),
    .ioOe_r(ioOe_r),
    .statusWord_r(statusWord_r),
    .fourWireMode_r(fourWireMode_r)
  );

  spi_host_model host (
    .clk(ref_clk),
    .sclk(sclk),
    .csN(csN),
    .hostIo(hostIo),
    .ioWire(ioWire)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic bad(input string m);
    badCount++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] want);
    nCompared++;
    if (got !== want) bad($sformatf("got %h want %h", got, want));
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    host.start();
    host.send(w, 8, {8'h00, op});
    host.stop();
  endtask

  task automatic rdStat(input logic [7:0] op, input int n,
                        input logic [7:0] x);
    host.start();
    host.send(w, 8, {8'h00, op});
    repeat (n) expQ.push_back(x);
    host.recv(w, n);
    host.stop();
  endtask

  task automatic wrStat(input int n, input logic [15:0] d);
    host.start();
    host.send(w, 8, 16'h0001);
    host.send(w, n, d);
    host.stop();
  endtask

  task automatic waitIdle();
    // look a step after the edge so the busy bit has settled
    for (int i = 0; i < 3 * WRC && statusWord_r[0] !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (statusWord_r[0] !== 1'b0) bad("busy stuck");
  endtask

  // every byte the host takes in is matched to the oldest note
  initial forever begin
    @(host.byteDone);
    e = (expQ.size() != 0) ? expQ.pop_front() : 8'hxx;
    nCompared++;
    if (host.rxByte !== e)
      bad($sformatf("read %h want %h", host.rxByte, e));
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    bad("watchdog");
    results();
  end

  initial begin
    seed = 32'hda66;
    w = 1;
    badCount = 0;
    nCompared = 0;
    arst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    host.tick(4);
    cmp16(statusWord_r, 16'h0000);
    cmp16({ioOe_r, 11'h000, fourWireMode_r}, 16'h0000);
    $display("reset test done");
    cmd(8'h06);
    rdStat(8'h05, 3, 8'h02);
    cmd(8'h04);
    rdStat(8'h05, 1, 8'h00);
    cmd(8'h38);
    cmp16({15'h0000, fourWireMode_r}, 16'h0000);
    $display("latch test done");
    cmd(8'h06);
    wrStat(16, 16'h0302);
    rdStat(8'h05, 1, 8'h03);
    waitIdle();
    cmp16(statusWord_r, 16'h0200);
    rdStat(8'h35, 2, 8'h02);
    $display("two byte write test done");
    r = 8'($random(seed)) & 8'h7c;
    cmd(8'h06);
    wrStat(8, {8'h00, r});
    waitIdle();
    cmp16(statusWord_r, {8'h02, r});
    cmd(8'h06);
    wrStat(12, 16'h0fff);
    cmp16(statusWord_r, {8'h02, r | 8'h02});
    cmd(8'h04);
    $display("one byte write test done");
    r2 = 8'($random(seed)) & 8'h7c;
    cmd(8'h50);
    wrStat(8, {8'h00, r2});
    cmp16(statusWord_r, {8'h02, r2});
    rdStat(8'h05, 1, r2);
    $display("volatile test done");
    cmd(8'h06);
    cmd(8'h38);
    cmp16({14'h0000, statusWord_r[1], fourWireMode_r}, 16'h0003);
    w = 4;
    rdStat(8'h05, 2, r2 | 8'h02);
    cmd(8'hff);
    w = 1;
    cmp16({14'h0000, statusWord_r[1], fourWireMode_r}, 16'h0002);
    cmd(8'h04);
    $display("four-wire test done");
    cmd(8'h06);
    wrStat(16, 16'h0003);
    waitIdle();
    cmp16(statusWord_r, 16'h0300);
    cmd(8'h06);
    wrStat(16, 16'h7c00);
    cmp16(statusWord_r & 16'hfffd, 16'h0300);
    $display("protect test done");
    r = 8'($random(seed));
    cmd(8'h06);
    host.start();
    host.send(1, 16, 16'h0200);
    // two bytes from the last page byte: the second wraps to its start
    host.send(1, 16, 16'h00ff);
    host.send(1, 16, {r, ~r});
    host.stop();
    waitIdle();
    cmp16(statusWord_r, 16'h0300);
    host.start();
    host.send(1, 8, 16'h006b);
    host.send(1, 16, 16'h0000);
    // low address byte, then eight dummy clocks
    host.send(1, 16, 16'hff00);
    expQ.push_back(r);
    expQ.push_back(~r);
    host.recv(4, 2);
    host.stop();
    $display("program test done");
    results();
  end
endmodule // serial_flash_config_status_cmds_bench

bind flash_cmd_front flash_front_chk #(.WR_CYCLES(WR_CYCLES)) chk (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .sclk(sclk),
  .csN(csN),
  .ioIn(ioIn),
  .ioOut_r(ioOut_r),
  .ioOe_r(ioOe_r),
  .statusWord_r(statusWord_r),
  .fourWireMode_r(fourWireMode_r)
);

// ### bench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  input wire clk,
  output logic sclk,
  output logic csN,
  output logic [3:0] hostIo,
  input wire [3:0] ioWire
);
  logic [7:0] rxByte;
  event byteDone;

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    hostIo = 4'hf;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // mode 0: sclk idles low, data set while low, taken at the rise
  task automatic pulse();
    tick(4);
    sclk = 1'b1;
    tick(4);
    sclk = 1'b0;
  endtask

  task automatic start();
    tick(1);
    csN = 1'b0;
  endtask

  // io2/io3 held high in serial frames so write protect stays released
  task automatic send(input int w, input int n, input logic [15:0] d);
    for (int i = n - w; i >= 0; i -= w) begin
      if (w == 4) hostIo = d[i +: 4];
      else hostIo = {3'b111, d[i]};
      pulse();
    end
  endtask

  // in quad reads all four lines toggle so a stale level never passes for data; serial reads toggle io0 only, not io1
  task automatic recv(input int w, input int nb);
    logic [7:0] b;
    for (int k = 0; k < nb; k++) begin
      for (int j = 0; j < 8; j += w) begin
        hostIo = (w == 4) ? ~hostIo : {hostIo[3:1], ~hostIo[0]};
        tick(4);
        sclk = 1'b1;
        b = (w == 4) ? {b[3:0], ioWire} : {b[6:0], ioWire[1]};
        tick(4);
        sclk = 1'b0;
      end
      rxByte = b;
      ->byteDone;
    end
  endtask

  task automatic stop();
    tick(4);
    csN = 1'b1;
    hostIo = 4'hf;
    tick(8);
  endtask
endmodule // spi_host_model

// ### src/byte_buf_mem.v
`timescale 1ns/1ps
module byte_buf_mem #(
  parameter AW = 10,
  parameter DW = 8
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] wAddr,
  input wire [DW-1:0] wData,
  input wire [AW-1:0] rAddr,
  output reg [DW-1:0] rData_r
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[wAddr] <= wData;
    end
    rData_r <= mem[rAddr];
  end
endmodule // byte_buf_mem

// ### src/flash_cmd_defs.vh
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH

`define REF_CLK_MHZ 50
`define WR_TIME_NS 10000
`define WR_CYCLES ((`WR_TIME_NS * `REF_CLK_MHZ + 999) / 1000)

`define OP_WR_EN 8'h06
`define OP_WR_DIS 8'h04
`define OP_VOL_EN 8'h50
`define OP_RD_SR_LO 8'h05
`define OP_RD_SR_HI 8'h35
`define OP_WR_SR 8'h01
`define OP_WR_SR_HI 8'h31
`define OP_ENTER_4W 8'h38
`define OP_EXIT_4W 8'hff
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_SET_PARAM 8'hc0
`define OP_PROG 8'h02
`define OP_SEC_PROG 8'h42
`define OP_SEC_ERASE 8'h44
`define OP_SEC_READ 8'h48
`define OP_SECT_ERASE 8'h20
`define OP_BLK32_ERASE 8'h52
`define OP_BLK64_ERASE 8'hd8
`define OP_CHIP_ERASE 8'hc7
`define OP_CHIP_ERASE2 8'h60
`define OP_READ 8'h03
`define OP_FAST 8'h0b
`define OP_WRAP_RD 8'h0c
`define OP_DUAL_OUT 8'h3b
`define OP_QUAD_OUT 8'h6b
`define OP_DUAL_IO 8'hbb
`define OP_QUAD_IO 8'heb
`define OP_WORD_IO 8'he7
`define OP_OCT_IO 8'he3

`define SR_QE 9
`define SR_PROT_LO 7
`define SR_PROT_HI 8
`define SR_RESET 14'h0000
`define SR_WMASK 16'h7ffc
`define RDPARAM_RESET 8'h00

`define SEC_ADDR_HI 8'h00
`define SEC1_ADDR_MID 8'h10
`define SEC2_ADDR_MID 8'h20
`define SEC3_ADDR_MID 8'h30

`define DUMMY_SPI_CLKS 4'd8
`define DUMMY_QIO_CLKS 4'd4
`define DUMMY_WORD_CLKS 4'd2
`define DUMMY_P_LO 4'd4
`define DUMMY_P_MID 4'd6
`define DUMMY_P_HI 4'd8
`define WRAP_MIN 8'h08

`endif

// ### src/flash_cmd_front.v
`timescale 1ns/1ps
`include "flash_cmd_defs.vh"

// Overview of operation
// - every byte moves most significant bit first, both directions
// - status reads repeat the same byte until chip select rises
// - program takes 1..256 bytes; excess wraps within the same page
// - security regions chosen by address 00h and 10h/20h/30h
// - dual transfers carry odd bit on line 1, even bit on line 0
// - quad transfers carry a nibble per clock, line 3 highest
// - quad io fast read leaves four dummy clocks after mode byte
// - word quad read two dummy clocks; octal word read none
// - four-wire mode sends opcode as two nibbles, then address
// - four-wire read dummy count and wrap length from read params
// - 06h sets write enable latch, 04h clears it
// - latch clears at reset and when writes or erases complete
// - 05h/35h return low/high status, accepted even while busy
// - status writes never change bits 15, 1 and 0
// - status write only executes on exact byte boundary
// - valid status write starts timed busy cycle, then clears latch
// - hardware protected mode blocks every status write
// - 01h with sixteen bits writes both bytes, eight bits low only
// - 50h lets next status write update volatile bits, no cycle
// - 38h enters four-wire mode only when quad enable is set
// - after reset the device is in serial command mode
// - entering four-wire mode keeps latch and wrap settings
// - ffh in four-wire mode returns to serial, keeping settings
module flash_cmd_front #(
  parameter [23:0] WR_CYCLES = `WR_CYCLES
) (
  input wire ref_clk,
  input wire arst_n,
  input wire sclk,
  input wire csN,
  input wire [3:0] ioIn,
  output reg [3:0] ioOut_r,
  output reg [3:0] ioOe_r,
  output reg [15:0] statusWord_r,
  output reg fourWireMode_r
);
  localparam [6:0] S_CMD = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_MODE = 7'h04;
  localparam [6:0] S_DUMMY = 7'h08;
  localparam [6:0] S_DIN = 7'h10;
  localparam [6:0] S_DOUT = 7'h20;
  localparam [6:0] S_SKIP = 7'h40;

  wire [5:0] syncOut;
  wire sclkS;
  wire csS;
  wire [3:0] ioS;
  reg sclkD_r;
  reg csD_r;
  reg [6:0] state_r;
  reg [7:0] op_r;
  reg [23:0] sh_r;
  reg [5:0] bitCnt_r;
  reg [1:0] byteCnt_r;
  reg [23:0] addr_r;
  reg [1:0] sel_r;
  reg [3:0] dummyLen_r;
  reg [7:0] wsrLo_r;
  reg [7:0] wsrHi_r;
  reg [15:2] srBits_r;
  reg wel_r;
  reg busy_r;
  reg [23:0] wrCnt_r;
  reg volWen_r;
  reg rstArm_r;
  reg progOk_r;
  reg [7:0] param_r;
  reg [7:0] txSh_r;
  reg [3:0] txCnt_r;
  wire [7:0] memRd;

  // the pin samples lag by two ref cycles; an sclk half period must
  // stay above about four ref cycles for edges to be seen in order
  sync_2ff #(
    .WIDTH(6),
    .INIT(6'h10)
  ) uSync (
    .clk(ref_clk),
    .arstN(arst_n),
    .din({sclk, csN, ioIn}),
    .dout_r(syncOut)
  );
  assign sclkS = syncOut[5];
  assign csS = syncOut[4];
  assign ioS = syncOut[3:0];

  wire rise = sclkS & ~sclkD_r & ~csS;
  wire fall = ~sclkS & sclkD_r & ~csS;
  wire csRise = csS & ~csD_r;

  function cmdOk;
    input [7:0] op;
    input four_wire_command_mode;
    input qe;
    begin
      case (op)
        `OP_WR_EN, `OP_WR_DIS, `OP_VOL_EN, `OP_RD_SR_LO, `OP_RD_SR_HI,
        `OP_WR_SR, `OP_WR_SR_HI, `OP_RST_EN, `OP_RST, `OP_PROG,
        `OP_SECT_ERASE, `OP_BLK32_ERASE, `OP_BLK64_ERASE,
        `OP_CHIP_ERASE, `OP_CHIP_ERASE2, `OP_FAST, `OP_QUAD_IO:
          cmdOk = 1'b1;
        `OP_SET_PARAM, `OP_EXIT_4W, `OP_WRAP_RD:
          cmdOk = four_wire_command_mode;
        `OP_ENTER_4W, `OP_READ, `OP_DUAL_OUT, `OP_DUAL_IO,
        `OP_SEC_PROG, `OP_SEC_ERASE, `OP_SEC_READ:
          cmdOk = ~four_wire_command_mode;
        `OP_QUAD_OUT, `OP_WORD_IO, `OP_OCT_IO:
          cmdOk = ~four_wire_command_mode & qe;
        default:
          cmdOk = 1'b0;
      endcase
    end
  endfunction

  function isRead;
    input [7:0] op;
    begin
      case (op)
        `OP_READ, `OP_FAST, `OP_WRAP_RD, `OP_DUAL_OUT, `OP_QUAD_OUT,
        `OP_DUAL_IO, `OP_QUAD_IO, `OP_WORD_IO, `OP_OCT_IO, `OP_SEC_READ:
          isRead = 1'b1;
        default:
          isRead = 1'b0;
      endcase
    end
  endfunction

  function needsAddr;
    input [7:0] op;
    begin
      case (op)
        `OP_PROG, `OP_SEC_PROG, `OP_SEC_ERASE, `OP_SECT_ERASE,
        `OP_BLK32_ERASE, `OP_BLK64_ERASE:
          needsAddr = 1'b1;
        default:
          needsAddr = isRead(op);
      endcase
    end
  endfunction

  function hasMode;
    input [7:0] op;
    begin
      hasMode = (op == `OP_DUAL_IO) | (op == `OP_QUAD_IO) |
        (op == `OP_WORD_IO) | (op == `OP_OCT_IO);
    end
  endfunction

  function [2:0] laneFor;
    input [6:0] st;
    input [7:0] op;
    input four_wire_command_mode;
    begin
      laneFor = 3'd1;
      if (four_wire_command_mode) begin
        laneFor = 3'd4;
      end else if (st == S_ADDR || st == S_MODE || st == S_DOUT) begin
        if (op == `OP_DUAL_IO || (st == S_DOUT && op == `OP_DUAL_OUT)) begin
          laneFor = 3'd2;
        end else if (hasMode(op) ||
            (st == S_DOUT && op == `OP_QUAD_OUT)) begin
          laneFor = 3'd4;
        end
      end
    end
  endfunction

  function [3:0] dummyFor;
    input [7:0] op;
    input four_wire_command_mode;
    input [1:0] p;
    begin
      dummyFor = 4'd0;
      if (four_wire_command_mode) begin
        if (op == `OP_FAST || op == `OP_WRAP_RD || op == `OP_QUAD_IO) begin
          case (p)
            2'b10: dummyFor = `DUMMY_P_MID;
            2'b11: dummyFor = `DUMMY_P_HI;
            default: dummyFor = `DUMMY_P_LO;
          endcase
        end
      end else begin
        case (op)
          `OP_FAST, `OP_DUAL_OUT, `OP_QUAD_OUT, `OP_SEC_READ:
            dummyFor = `DUMMY_SPI_CLKS;
          `OP_QUAD_IO:
            dummyFor = `DUMMY_QIO_CLKS;
          `OP_WORD_IO:
            dummyFor = `DUMMY_WORD_CLKS;
          default:
            dummyFor = 4'd0;
        endcase
      end
    end
  endfunction

  function [23:0] stepAddr;
    input [23:0] a;
    input wrap;
    input [1:0] len;
    reg [7:0] m;
    reg [7:0] inc;
    begin
      m = (`WRAP_MIN << len) - 8'h01;
      inc = a[7:0] + 8'h01;
      // the low byte alone advances, so streams stay inside one page
      if (wrap) begin
        stepAddr = {a[23:8], (a[7:0] & ~m) | (inc & m)};
      end else begin
        stepAddr = {a[23:8], inc};
      end
    end
  endfunction

  wire [2:0] lanes = laneFor(state_r, op_r, fourWireMode_r);
  wire [5:0] bitNext = bitCnt_r + {3'b000, lanes};
  reg [23:0] rxNext;
  always @* begin
    case (lanes)
      3'd4: rxNext = {sh_r[19:0], ioS};
      3'd2: rxNext = {sh_r[21:0], ioS[1:0]};
      default: rxNext = {sh_r[22:0], ioS[0]};
    endcase
  end

  wire qe = srBits_r[`SR_QE];
  wire [15:0] srNow = {srBits_r, wel_r, busy_r};
  wire [7:0] opIn = rxNext[7:0];
  wire statusRdIn = (opIn == `OP_RD_SR_LO) | (opIn == `OP_RD_SR_HI);
  wire secOp = (op_r == `OP_SEC_PROG) | (op_r == `OP_SEC_ERASE) |
    (op_r == `OP_SEC_READ);
  wire [7:0] midIn = rxNext[15:8];
  wire secAddrOk = (rxNext[23:16] == `SEC_ADDR_HI) &
    ((midIn == `SEC1_ADDR_MID) | (midIn == `SEC2_ADDR_MID) |
    (midIn == `SEC3_ADDR_MID));
  wire isProg = (op_r == `OP_PROG) | (op_r == `OP_SEC_PROG);
  wire isErase = (op_r == `OP_SECT_ERASE) | (op_r == `OP_BLK32_ERASE) |
    (op_r == `OP_BLK64_ERASE) | (op_r == `OP_CHIP_ERASE) |
    (op_r == `OP_CHIP_ERASE2) | (op_r == `OP_SEC_ERASE);
  wire dinByte = rise & (state_r == S_DIN) & (bitNext == 6'd8);
  wire memWe = dinByte & isProg & progOk_r;
  wire [9:0] memAddr = {sel_r, addr_r[7:0]};

  // the write protect pin is shared with io2 and only counts in plain
  // serial use with quad disabled
  wire wpN = fourWireMode_r | qe | ioS[2];
  wire hwLock = srBits_r[`SR_PROT_HI] | (srBits_r[`SR_PROT_LO] & ~wpN);
  wire wsrLenOk = (op_r == `OP_WR_SR) ?
    (byteCnt_r == 2'd1 || byteCnt_r == 2'd2) : (byteCnt_r == 2'd1);
  wire wsrOk = (state_r == S_DIN) & (bitCnt_r == 6'd0) & wsrLenOk &
    (wel_r | volWen_r) & ~hwLock;
  wire [7:0] wsrHiVal = (op_r == `OP_WR_SR_HI) ? wsrLo_r :
    ((byteCnt_r == 2'd2) ? wsrHi_r : srNow[15:8]);
  wire [7:0] wsrLoVal = (op_r == `OP_WR_SR) ? wsrLo_r : srNow[7:0];
  wire [15:0] wsrVal = ({wsrHiVal, wsrLoVal} & `SR_WMASK) |
    (srNow & ~`SR_WMASK);

  wire [7:0] txSrc = (op_r == `OP_RD_SR_LO) ? srNow[7:0] :
    ((op_r == `OP_RD_SR_HI) ? srNow[15:8] : memRd);
  wire [7:0] txByte = (txCnt_r == 4'd0) ? txSrc : txSh_r;
  wire wrapOn = fourWireMode_r & (op_r == `OP_WRAP_RD);

  byte_buf_mem #(
    .AW(10),
    .DW(8)
  ) uMem (
    .clk(ref_clk),
    .we(memWe),
    .wAddr(memAddr),
    .wData(rxNext[7:0]),
    .rAddr(memAddr),
    .rData_r(memRd)
  );

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkD_r <= 1'b0;
      csD_r <= 1'b1;
      state_r <= S_CMD;
      op_r <= 8'h00;
      sh_r <= 24'h000000;
      bitCnt_r <= 6'h00;
      byteCnt_r <= 2'h0;
      addr_r <= 24'h000000;
      sel_r <= 2'h0;
      dummyLen_r <= 4'h0;
      wsrLo_r <= 8'h00;
      wsrHi_r <= 8'h00;
      srBits_r <= `SR_RESET;
      wel_r <= 1'b0;
      busy_r <= 1'b0;
      wrCnt_r <= 24'h000000;
      volWen_r <= 1'b0;
      rstArm_r <= 1'b0;
      progOk_r <= 1'b0;
      param_r <= `RDPARAM_RESET;
      txSh_r <= 8'h00;
      txCnt_r <= 4'h0;
      ioOut_r <= 4'h0;
      ioOe_r <= 4'h0;
      statusWord_r <= 16'h0000;
      fourWireMode_r <= 1'b0;
    end else begin
      sclkD_r <= sclkS;
      csD_r <= csS;
      statusWord_r <= srNow;
      if (busy_r) begin
        if (wrCnt_r >= WR_CYCLES - 24'h000001) begin
          busy_r <= 1'b0;
          wel_r <= 1'b0;
        end else begin
          wrCnt_r <= wrCnt_r + 24'h000001;
        end
      end
      if (csS) begin
        state_r <= S_CMD;
        bitCnt_r <= 6'h00;
        byteCnt_r <= 2'h0;
        txCnt_r <= 4'h0;
        ioOe_r <= 4'h0;
      end
      if (csRise && state_r != S_CMD && state_r != S_SKIP) begin
        volWen_r <= 1'b0;
        rstArm_r <= 1'b0;
        case (op_r)
          `OP_WR_EN: wel_r <= 1'b1;
          `OP_WR_DIS: wel_r <= 1'b0;
          `OP_VOL_EN: volWen_r <= 1'b1;
          `OP_ENTER_4W: begin
            // only the mode flag moves; latch and wrap settings stay
            if (qe) begin
              fourWireMode_r <= 1'b1;
            end
          end
          `OP_EXIT_4W: fourWireMode_r <= 1'b0;
          `OP_RST_EN: rstArm_r <= 1'b1;
          `OP_RST: begin
            if (rstArm_r) begin
              wel_r <= 1'b0;
              param_r <= `RDPARAM_RESET;
            end
          end
          `OP_WR_SR, `OP_WR_SR_HI: begin
            if (wsrOk) begin
              srBits_r <= wsrVal[15:2];
              if (!volWen_r) begin
                busy_r <= 1'b1;
                wrCnt_r <= 24'h000000;
              end
            end
          end
          default: begin
            if (progOk_r && bitCnt_r == 6'd0 && state_r == S_DIN &&
                ((isProg && byteCnt_r != 2'd0) ||
                (isErase && byteCnt_r == 2'd0))) begin
              busy_r <= 1'b1;
              wrCnt_r <= 24'h000000;
            end
          end
        endcase
      end else if (rise) begin
        if (state_r != S_DOUT && state_r != S_SKIP) begin
          sh_r <= rxNext;
        end
        case (state_r)
          S_CMD: begin
            if (bitNext == 6'd8) begin
              op_r <= opIn;
              bitCnt_r <= 6'h00;
              progOk_r <= wel_r;
              if (!cmdOk(opIn, fourWireMode_r, qe) ||
                  (busy_r && !statusRdIn)) begin
                state_r <= S_SKIP;
              end else if (statusRdIn) begin
                state_r <= S_DOUT;
              end else if (needsAddr(opIn)) begin
                state_r <= S_ADDR;
              end else begin
                state_r <= S_DIN;
              end
            end else begin
              bitCnt_r <= bitNext;
            end
          end
          S_ADDR: begin
            if (bitNext == 6'd24) begin
              addr_r <= rxNext;
              bitCnt_r <= 6'h00;
              sel_r <= secOp ? rxNext[13:12] : 2'h0;
              dummyLen_r <= dummyFor(op_r, fourWireMode_r, param_r[5:4]);
              if (secOp && !secAddrOk) begin
                state_r <= S_SKIP;
              end else if (hasMode(op_r)) begin
                state_r <= S_MODE;
              end else if (!isRead(op_r)) begin
                state_r <= S_DIN;
              end else if (dummyFor(op_r, fourWireMode_r, param_r[5:4]) ==
                  4'd0) begin
                state_r <= S_DOUT;
              end else begin
                state_r <= S_DUMMY;
              end
            end else begin
              bitCnt_r <= bitNext;
            end
          end
          S_MODE: begin
            if (bitNext == 6'd8) begin
              bitCnt_r <= 6'h00;
              state_r <= (dummyLen_r == 4'd0) ? S_DOUT : S_DUMMY;
            end else begin
              bitCnt_r <= bitNext;
            end
          end
          S_DUMMY: begin
            if (bitCnt_r[3:0] + 4'd1 == dummyLen_r) begin
              bitCnt_r <= 6'h00;
              state_r <= S_DOUT;
            end else begin
              bitCnt_r <= bitCnt_r + 6'h01;
            end
          end
          S_DIN: begin
            if (bitNext == 6'd8) begin
              bitCnt_r <= 6'h00;
              if (byteCnt_r == 2'd0) begin
                wsrLo_r <= rxNext[7:0];
              end
              if (byteCnt_r == 2'd1) begin
                wsrHi_r <= rxNext[7:0];
              end
              if (byteCnt_r != 2'd3) begin
                byteCnt_r <= byteCnt_r + 2'd1;
              end
              if (op_r == `OP_SET_PARAM && byteCnt_r == 2'd0) begin
                param_r <= rxNext[7:0];
              end
              if (memWe) begin
                addr_r <= stepAddr(addr_r, 1'b0, 2'b00);
              end
            end else begin
              bitCnt_r <= bitNext;
            end
          end
          default: begin
          end
        endcase
      end else if (fall && state_r == S_DOUT) begin
        if (txCnt_r == 4'd0 && op_r != `OP_RD_SR_LO &&
            op_r != `OP_RD_SR_HI) begin
          addr_r <= stepAddr(addr_r, wrapOn, param_r[1:0]);
        end
        txCnt_r <= ((txCnt_r == 4'd0) ? 4'd8 : txCnt_r) - {1'b0, lanes};
        case (lanes)
          3'd4: begin
            ioOut_r <= txByte[7:4];
            ioOe_r <= 4'hf;
            txSh_r <= {txByte[3:0], 4'h0};
          end
          3'd2: begin
            ioOut_r <= {2'b00, txByte[7:6]};
            ioOe_r <= 4'h3;
            txSh_r <= {txByte[5:0], 2'b00};
          end
          default: begin
            ioOut_r <= {2'b00, txByte[7], 1'b0};
            ioOe_r <= 4'h2;
            txSh_r <= {txByte[6:0], 1'b0};
          end
        endcase
      end
    end
  end
endmodule // flash_cmd_front

// ### src/sync_2ff.v
`timescale 1ns/1ps
module sync_2ff #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire arstN,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout_r
);
  reg [WIDTH-1:0] meta_r;

  always @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      meta_r <= INIT;
      dout_r <= INIT;
    end else begin
      meta_r <= din;
      dout_r <= meta_r;
    end
  end
endmodule // sync_2ff
